// File: itp_pkg.sv
// Package for the instruction trace port: field layouts and vector positions
package itp_pkg;

  // Field widths
  localparam int WORD_W    = 32;
  localparam int REG_IDX_W = 5;
  localparam int MSR_W     = 15;
  localparam int PID_W     = 8;
  localparam int EXC_W     = 5;
  localparam int BE_W      = 4;

  // Exception kinds; codes not listed are reserved
  typedef enum logic [4:0] {
    ITP_EXC_STREAM   = 5'h00,
    ITP_EXC_UNALIGN  = 5'h01,
    ITP_EXC_ILLEGAL  = 5'h02,
    ITP_EXC_IBUS     = 5'h03,
    ITP_EXC_DBUS     = 5'h04,
    ITP_EXC_DIVIDE   = 5'h05,
    ITP_EXC_FPU      = 5'h06,
    ITP_EXC_PRIV     = 5'h07,
    ITP_EXC_IRQ      = 5'h0a,
    ITP_EXC_NMBRK    = 5'h0b,
    ITP_EXC_MBRK     = 5'h0c,
    ITP_EXC_DSTORE   = 5'h10,
    ITP_EXC_ISTORE   = 5'h11,
    ITP_EXC_DTLB     = 5'h12,
    ITP_EXC_ITLB     = 5'h13
  } itp_exc_kind_t;

  // Comparison vector positions of the trace fields
  localparam int VEC_W         = 4096;
  localparam int POS_INSTR     = 3551;
  localparam int POS_VALID     = 3583;
  localparam int POS_PC        = 3584;
  localparam int POS_REG_WR    = 3616;
  localparam int POS_REG_IDX   = 3617;
  localparam int POS_MSR       = 3622;
  localparam int POS_PID       = 3637;
  localparam int POS_NEW_VAL   = 3645;
  localparam int POS_EXC_TAKEN = 3677;
  localparam int POS_EXC_KIND  = 3678;
  localparam int POS_JMP_TAKEN = 3683;
  localparam int POS_DELAY     = 3684;
  localparam int POS_D_ADDR    = 3685;
  localparam int POS_D_WVAL    = 3717;
  localparam int POS_D_BE      = 3749;
  localparam int POS_D_ACC     = 3753;
  localparam int POS_D_RD      = 3754;
  localparam int POS_D_WR      = 3755;
  localparam int POS_DC_REQ    = 3756;
  localparam int POS_DC_HIT    = 3757;
  localparam int POS_DC_DONE   = 3758;
  localparam int POS_DC_IS_RD  = 3759;
  localparam int POS_IC_REQ    = 3760;
  localparam int POS_IC_HIT    = 3761;
  localparam int POS_IC_DONE   = 3762;
  localparam int POS_DEC_ADV   = 3763;
  localparam int POS_EXE_ADV   = 3764;
  localparam int POS_MEM_ADV   = 3765;
  localparam int POS_HALTED    = 3766;
  localparam int POS_JMP_HIT   = 3767;
  localparam int POS_TRC_LO    = 3551;
  localparam int POS_TRC_HI    = 3767;
  localparam int TRC_SLICE_W   = POS_TRC_HI - POS_TRC_LO + 1;

  // One retired step of the pipeline
  typedef struct packed {
    logic [WORD_W-1:0]    instr;
    logic [WORD_W-1:0]    prog_counter;
    logic                 reg_wr;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [MSR_W-1:0]     machine_status;
    logic [PID_W-1:0]     process_ident;
    logic [WORD_W-1:0]    new_reg_val;
    logic                 exc_taken;
    logic [EXC_W-1:0]     exc_kind;
    logic                 jmp_taken;
    logic                 jmp_hit;
    logic                 delay_slot;
    logic                 d_access;
    logic                 d_read;
    logic                 d_write;
    logic [WORD_W-1:0]    d_addr;
    logic [WORD_W-1:0]    d_wval;
    logic [BE_W-1:0]      d_be;
  } itp_instr_t;

  // Per-cycle cache and pipeline status
  typedef struct packed {
    logic dc_request;
    logic dc_hit;
    logic dc_done;
    logic dc_is_rd;
    logic ic_request;
    logic ic_hit;
    logic ic_done;
    logic decode_advance;
    logic execute_advance;
    logic memstage_advance;
    logic debug_halted;
  } itp_status_t;

endpackage

// File: itp_trace_port.sv
// Instruction trace port: registers trace outputs and comparison slice
//
// Overview of operation
// - Valid strobe marks a presented retired instruction
// - Instruction fields meaningful only while valid high
// - Register-write flag with 5-bit destination index
// - Output 32-bit value written to destination
// - Flag instructions whose result takes an exception
// - Report exception type as 5-bit code
// - Exception kind meaningful only with taken flag
// - Fixed encodings for unaligned, divide, interrupt, breaks
// - Unassigned exception codes are never emitted
// - Branch-taken flag when branch evaluates true
// - Branch-target-cache hit flag, absent when small
// - Flag instruction in taken branch delay slot
// - Data-access valid plus read and write flags
// - Data address, write value, byte enables output
// - Data cache request and hit flags
// - Data cache read flag qualified by request
// - Instruction cache request, hit and done flags
// - Stage advance pulses; execute, memory absent small
// - Halted output while debug holds pipeline
// - Trace slice at 3551..3767, rest reserved
// - Wide fields compare from lowest bit up
`timescale 1ns/1ps

module itp_trace_port #(
  parameter bit small_area_option = 1'b0
) (
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  // Pipeline side
  input  wire logic                      step_valid_i,
  output logic                           step_ready_o,
  input  wire itp_pkg::itp_instr_t       step_i,
  input  wire itp_pkg::itp_status_t      status_i,
  // Trace sampler side
  input  wire logic                      trc_ready_i,
  output logic                           trc_valid_instr_o,
  output itp_pkg::itp_instr_t            trc_instr_o,
  output itp_pkg::itp_status_t           trc_status_o,
  output logic [itp_pkg::VEC_W-1:0]      trc_cmp_vec_o
);

  typedef logic [itp_pkg::EXC_W-1:0] itp_code_t;

  initial
  begin
    if (itp_pkg::POS_TRC_HI >= itp_pkg::VEC_W)
      $error("Trace slice beyond comparison vector");
  end

  // Known exception codes; anything else is reserved
  function automatic logic itp_code_known(input itp_code_t c);
    logic ok;
    ok = 1'b0;
    unique case (c)
      itp_pkg::ITP_EXC_STREAM, itp_pkg::ITP_EXC_UNALIGN,
      itp_pkg::ITP_EXC_ILLEGAL, itp_pkg::ITP_EXC_IBUS,
      itp_pkg::ITP_EXC_DBUS, itp_pkg::ITP_EXC_DIVIDE,
      itp_pkg::ITP_EXC_FPU, itp_pkg::ITP_EXC_PRIV,
      itp_pkg::ITP_EXC_IRQ, itp_pkg::ITP_EXC_NMBRK,
      itp_pkg::ITP_EXC_MBRK, itp_pkg::ITP_EXC_DSTORE,
      itp_pkg::ITP_EXC_ISTORE, itp_pkg::ITP_EXC_DTLB,
      itp_pkg::ITP_EXC_ITLB: ok = 1'b1;
      default:               ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Two-entry buffer; a stalled sampler loses no retired step
  itp_pkg::itp_instr_t buf_ff [2];
  logic [1:0]          cnt_ff;
  logic                rd_ptr_ff;
  logic                wr_ptr_ff;
  logic                push;
  logic                pop;
  logic [1:0]          nxt_cnt;

  assign push    = step_valid_i && step_ready_o;
  assign pop     = (cnt_ff != 2'h0) && trc_ready_i;
  assign nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clock_i)
  begin
    if (push)
      buf_ff[wr_ptr_ff] <= step_i;
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_ff       <= 2'h0;
      rd_ptr_ff    <= 1'b0;
      wr_ptr_ff    <= 1'b0;
      step_ready_o <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= nxt_cnt;
      // Ready from the next count, so the pin comes straight from a flop
      step_ready_o <= (nxt_cnt != 2'h2);
    end
  end

  // Sanitised head entry
  itp_pkg::itp_instr_t nxt_instr;
  itp_pkg::itp_status_t nxt_status;

  always_comb
  begin
    nxt_instr = buf_ff[rd_ptr_ff];
    // Exception fields forced quiet unless a legal code is taken
    if (!nxt_instr.exc_taken || !itp_code_known(nxt_instr.exc_kind))
    begin
      nxt_instr.exc_taken = 1'b0;
      nxt_instr.exc_kind  = '0;
    end
    if (!nxt_instr.reg_wr)
      nxt_instr.reg_idx = '0;
    nxt_instr.jmp_hit = nxt_instr.jmp_hit & ~small_area_option;
    // Only one direction per data access
    nxt_instr.d_read  = nxt_instr.d_access & nxt_instr.d_read;
    nxt_instr.d_write = nxt_instr.d_access & nxt_instr.d_write
                        & ~nxt_instr.d_read;
    nxt_status = status_i;
    nxt_status.dc_is_rd = status_i.dc_request & status_i.dc_is_rd;
    nxt_status.dc_hit   = status_i.dc_request & status_i.dc_hit;
    nxt_status.ic_hit   = status_i.ic_request & status_i.ic_hit;
    nxt_status.ic_done  = status_i.ic_request & status_i.ic_done;
    if (small_area_option)
    begin
      nxt_status.execute_advance  = 1'b0;
      nxt_status.memstage_advance = 1'b0;
    end
  end

  // Outputs; instruction fields hold between steps, all change together
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      trc_valid_instr_o <= 1'b0;
      trc_instr_o       <= '0;
    end
    else
    begin
      trc_valid_instr_o <= pop;
      if (pop)
        trc_instr_o <= nxt_instr;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      trc_status_o <= '0;
    else
      trc_status_o <= nxt_status;
  end

  // Vector shows the step the outputs show, also between pulses,
  // so an empty buffer never leaks unwritten entries into it
  itp_pkg::itp_instr_t vec_instr;
  assign vec_instr = pop ? nxt_instr : trc_instr_o;

  // Comparison vector; reserved positions stay zero
  logic [itp_pkg::VEC_W-1:0] nxt_vec;
  always_comb
  begin
    nxt_vec = '0;
    // Fields sit from their lowest position up to the signal width
    nxt_vec[itp_pkg::POS_INSTR +: itp_pkg::WORD_W] = vec_instr.instr;
    nxt_vec[itp_pkg::POS_VALID] = pop;
    nxt_vec[itp_pkg::POS_PC +: itp_pkg::WORD_W] = vec_instr.prog_counter;
    nxt_vec[itp_pkg::POS_REG_WR] = vec_instr.reg_wr;
    nxt_vec[itp_pkg::POS_REG_IDX +: itp_pkg::REG_IDX_W] = vec_instr.reg_idx;
    nxt_vec[itp_pkg::POS_MSR +: itp_pkg::MSR_W] = vec_instr.machine_status;
    nxt_vec[itp_pkg::POS_PID +: itp_pkg::PID_W] = vec_instr.process_ident;
    nxt_vec[itp_pkg::POS_NEW_VAL +: itp_pkg::WORD_W] = vec_instr.new_reg_val;
    nxt_vec[itp_pkg::POS_EXC_TAKEN] = vec_instr.exc_taken;
    nxt_vec[itp_pkg::POS_EXC_KIND +: itp_pkg::EXC_W] = vec_instr.exc_kind;
    nxt_vec[itp_pkg::POS_JMP_TAKEN] = vec_instr.jmp_taken;
    nxt_vec[itp_pkg::POS_DELAY] = vec_instr.delay_slot;
    nxt_vec[itp_pkg::POS_D_ADDR +: itp_pkg::WORD_W] = vec_instr.d_addr;
    nxt_vec[itp_pkg::POS_D_WVAL +: itp_pkg::WORD_W] = vec_instr.d_wval;
    nxt_vec[itp_pkg::POS_D_BE +: itp_pkg::BE_W] = vec_instr.d_be;
    nxt_vec[itp_pkg::POS_D_ACC] = vec_instr.d_access;
    nxt_vec[itp_pkg::POS_D_RD] = vec_instr.d_read;
    nxt_vec[itp_pkg::POS_D_WR] = vec_instr.d_write;
    nxt_vec[itp_pkg::POS_DC_REQ] = nxt_status.dc_request;
    nxt_vec[itp_pkg::POS_DC_HIT] = nxt_status.dc_hit;
    nxt_vec[itp_pkg::POS_DC_DONE] = nxt_status.dc_done;
    nxt_vec[itp_pkg::POS_DC_IS_RD] = nxt_status.dc_is_rd;
    nxt_vec[itp_pkg::POS_IC_REQ] = nxt_status.ic_request;
    nxt_vec[itp_pkg::POS_IC_HIT] = nxt_status.ic_hit;
    nxt_vec[itp_pkg::POS_IC_DONE] = nxt_status.ic_done;
    nxt_vec[itp_pkg::POS_DEC_ADV] = nxt_status.decode_advance;
    nxt_vec[itp_pkg::POS_EXE_ADV] = nxt_status.execute_advance;
    nxt_vec[itp_pkg::POS_MEM_ADV] = nxt_status.memstage_advance;
    nxt_vec[itp_pkg::POS_HALTED] = nxt_status.debug_halted;
    nxt_vec[itp_pkg::POS_JMP_HIT] = vec_instr.jmp_hit;
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      trc_cmp_vec_o <= '0;
    else
      trc_cmp_vec_o <= nxt_vec;
  end

  // Checks
  property p_valid_follows_pop;
    @(posedge clock_i) disable iff (reset_i)
    (cnt_ff != 2'h0 && trc_ready_i) |=> trc_valid_instr_o;
  endproperty
  a_valid_follows_pop: assert property (p_valid_follows_pop)
    else $error("Valid strobe missed a buffered step");

  property p_hold_when_idle;
    @(posedge clock_i) disable iff (reset_i)
    !trc_valid_instr_o |-> $stable(trc_instr_o);
  endproperty
  a_hold_when_idle: assert property (p_hold_when_idle)
    else $error("Instruction fields changed without valid");

  property p_kind_quiet;
    @(posedge clock_i) disable iff (reset_i)
    !trc_instr_o.exc_taken |-> trc_instr_o.exc_kind == '0;
  endproperty
  a_kind_quiet: assert property (p_kind_quiet)
    else $error("Exception kind set without taken flag");

  property p_no_reserved;
    @(posedge clock_i) disable iff (reset_i)
    trc_instr_o.exc_taken |-> itp_code_known(trc_instr_o.exc_kind);
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("Reserved exception code emitted");

  property p_dir_exclusive;
    @(posedge clock_i) disable iff (reset_i)
    (trc_instr_o.d_read || trc_instr_o.d_write) |->
      trc_instr_o.d_access && !(trc_instr_o.d_read && trc_instr_o.d_write);
  endproperty
  a_dir_exclusive: assert property (p_dir_exclusive)
    else $error("Data direction flags inconsistent");

  property p_dc_read_qual;
    @(posedge clock_i) disable iff (reset_i)
    trc_status_o.dc_is_rd |-> trc_status_o.dc_request;
  endproperty
  a_dc_read_qual: assert property (p_dc_read_qual)
    else $error("Cache read flag without request");

  property p_halted_tracks;
    @(posedge clock_i) disable iff (reset_i)
    status_i.debug_halted |=> trc_status_o.debug_halted
      && trc_cmp_vec_o[itp_pkg::POS_HALTED];
  endproperty
  a_halted_tracks: assert property (p_halted_tracks)
    else $error("Halted output did not follow the pipeline");

  property p_vec_valid;
    @(posedge clock_i) disable iff (reset_i)
    trc_cmp_vec_o[itp_pkg::POS_VALID] == trc_valid_instr_o;
  endproperty
  a_vec_valid: assert property (p_vec_valid)
    else $error("Vector valid bit disagrees with strobe");

  property p_small_area;
    @(posedge clock_i) disable iff (reset_i)
    small_area_option |-> !trc_status_o.execute_advance
      && !trc_status_o.memstage_advance && !trc_instr_o.jmp_hit;
  endproperty
  a_small_area: assert property (p_small_area)
    else $error("Omitted signal active in small configuration");

  property p_idx_quiet;
    @(posedge clock_i) disable iff (reset_i)
    !trc_instr_o.reg_wr |-> trc_instr_o.reg_idx == '0;
  endproperty
  a_idx_quiet: assert property (p_idx_quiet)
    else $error("Destination index set without register write");

  property p_dc_hit_qual;
    @(posedge clock_i) disable iff (reset_i)
    trc_status_o.dc_hit |-> trc_status_o.dc_request;
  endproperty
  a_dc_hit_qual: assert property (p_dc_hit_qual)
    else $error("Data cache hit without request");

  property p_ic_qual;
    @(posedge clock_i) disable iff (reset_i)
    (trc_status_o.ic_hit || trc_status_o.ic_done) |->
      trc_status_o.ic_request;
  endproperty
  a_ic_qual: assert property (p_ic_qual)
    else $error("Instruction cache flag without request");

  property p_vec_reserved;
    @(posedge clock_i) disable iff (reset_i)
    trc_cmp_vec_o[itp_pkg::VEC_W-1:itp_pkg::POS_TRC_HI+1] == '0
      && trc_cmp_vec_o[itp_pkg::POS_TRC_LO-1:0] == '0;
  endproperty
  a_vec_reserved: assert property (p_vec_reserved)
    else $error("Reserved vector position set");

endmodule

// File: itp_trace_sampler.sv
// Trace sampler model that records presented steps
`timescale 1ns/1ps

module itp_trace_sampler (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  // Pace control
  input  wire logic                slow_i,
  // Trace side
  input  wire logic                trc_valid_instr_i,
  input  wire itp_pkg::itp_instr_t trc_instr_i,
  output logic                     trc_ready_o
);
  itp_pkg::itp_instr_t seen_q[$];
  logic [1:0]          phase_ff = 2'h0;

  initial trc_ready_o = 1'b0;

  // Slow pace takes one cycle in four, so the buffer backs up
  always @(negedge clock_i)
  begin
    phase_ff    <= phase_ff + 2'h1;
    trc_ready_o <= !slow_i || (phase_ff == 2'h3);
  end

  // Fields kept only on the strobe
  always @(posedge clock_i)
  begin
    if (!reset_i && trc_valid_instr_i === 1'b1)
    begin
      seen_q.push_back(trc_instr_i);
    end
  end
endmodule

// File: test_instruction_trace_port.sv
// Self-checking bench for the trace port
`timescale 1ns/1ps

module test_instruction_trace_port;
  logic                clock_i = 1'b0;
  logic                reset_i = 1'b1;
  logic                step_valid_i = 1'b0;
  logic                step_ready_o;
  itp_pkg::itp_instr_t step_i = '0;
  itp_pkg::itp_status_t status_i = '0;
  logic                trc_ready;
  logic                trc_valid_instr_o;
  itp_pkg::itp_instr_t trc_instr_o;
  itp_pkg::itp_status_t trc_status_o;
  logic [4095:0]       trc_cmp_vec_o;
  logic                slow = 1'b0;
  logic                st_live = 1'b0;
  logic [31:0]         s1 = 32'h0000_64bf;
  logic [31:0]         s2 = 32'h0000_64bf;
  itp_pkg::itp_status_t last_st = '0;
  itp_pkg::itp_instr_t exp_q[$];
  int                  fail_count = 0;
  int                  samples_checked = 0;
  itp_pkg::itp_status_t exp_st;
  logic [216:0]        slice;
  logic [1:0]          occ = 2'h0;
  logic                exp_vld = 1'b0;
  itp_pkg::itp_instr_t sm_instr;
  itp_pkg::itp_status_t sm_status;
  logic [4095:0]       sm_vec;

  always #2.5 clock_i = ~clock_i;

  itp_trace_port u_dut (
    .clock_i          (clock_i),
    .reset_i          (reset_i),
    .step_valid_i     (step_valid_i),
    .step_ready_o     (step_ready_o),
    .step_i           (step_i),
    .status_i         (status_i),
    .trc_ready_i      (trc_ready),
    .trc_valid_instr_o(trc_valid_instr_o),
    .trc_instr_o      (trc_instr_o),
    .trc_status_o     (trc_status_o),
    .trc_cmp_vec_o    (trc_cmp_vec_o)
  );

  itp_trace_sampler u_smp (
    .clock_i          (clock_i),
    .reset_i          (reset_i),
    .slow_i           (slow),
    .trc_valid_instr_i(trc_valid_instr_o),
    .trc_instr_i      (trc_instr_o),
    .trc_ready_o      (trc_ready)
  );

  // Small configuration fed the same stream
  itp_trace_port #(
    .small_area_option(1'b1)
  ) u_dut_small (
    .clock_i          (clock_i),
    .reset_i          (reset_i),
    .step_valid_i     (step_valid_i),
    .step_ready_o     (),
    .step_i           (step_i),
    .status_i         (status_i),
    .trc_ready_i      (trc_ready),
    .trc_valid_instr_o(),
    .trc_instr_o      (sm_instr),
    .trc_status_o     (sm_status),
    .trc_cmp_vec_o    (sm_vec)
  );

  // Two-entry buffer occupancy and the strobe it should give
  always @(posedge clock_i)
  begin
    exp_vld <= !reset_i && occ != 2'h0 && trc_ready === 1'b1;
    if (reset_i)
      occ <= 2'h0;
    else
      occ <= occ + 2'(step_valid_i === 1'b1 && occ != 2'h2)
             - 2'(occ != 2'h0 && trc_ready === 1'b1);
  end

  function automatic logic [31:0] xs(ref logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic bit legal(logic [4:0] k);
    return k <= 5'h07 || (k >= 5'h0a && k <= 5'h0c)
           || (k >= 5'h10 && k <= 5'h13);
  endfunction

  function automatic itp_pkg::itp_instr_t exp_of(itp_pkg::itp_instr_t s);
    itp_pkg::itp_instr_t e;
    e = s;
    e.exc_taken = s.exc_taken && legal(s.exc_kind);
    if (!e.exc_taken)
    begin
      e.exc_kind = 5'h00;
    end
    if (!s.reg_wr)
    begin
      e.reg_idx = 5'h00;
    end
    e.d_read  = s.d_access & s.d_read;
    e.d_write = s.d_access & s.d_write & ~s.d_read;
    return e;
  endfunction

  function automatic itp_pkg::itp_status_t st_of(itp_pkg::itp_status_t s,
                                                 bit sm);
    itp_pkg::itp_status_t e;
    e = s;
    // Data cache done passes ungated
    e.dc_hit   = s.dc_hit & s.dc_request;
    e.dc_is_rd = s.dc_is_rd & s.dc_request;
    e.ic_hit   = s.ic_hit & s.ic_request;
    e.ic_done  = s.ic_done & s.ic_request;
    if (sm)
    begin
      e.execute_advance  = 1'b0;
      e.memstage_advance = 1'b0;
    end
    return e;
  endfunction

  // Trace slice as laid out in the vector, highest field first
  function automatic logic [216:0] vec_of(itp_pkg::itp_instr_t i,
      itp_pkg::itp_status_t t, logic v);
    return {i.jmp_hit, t.debug_halted, t.memstage_advance,
            t.execute_advance, t.decode_advance, t.ic_done, t.ic_hit,
            t.ic_request, t.dc_is_rd, t.dc_done, t.dc_hit, t.dc_request,
            i.d_write, i.d_read, i.d_access, i.d_be, i.d_wval, i.d_addr,
            i.delay_slot, i.jmp_taken, i.exc_kind, i.exc_taken,
            i.new_reg_val, i.process_ident, i.machine_status, i.reg_idx,
            i.reg_wr, i.prog_counter, v, i.instr};
  endfunction

  task automatic miss(logic [255:0] g, logic [255:0] e);
    fail_count++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
  endtask

  task automatic cmp_instr(itp_pkg::itp_instr_t g, itp_pkg::itp_instr_t e);
    samples_checked++;
    if (g !== e) miss(256'(g), 256'(e));
  endtask

  task automatic cmp_stat(itp_pkg::itp_status_t g, itp_pkg::itp_status_t e);
    samples_checked++;
    if (g !== e) miss(256'(g), 256'(e));
  endtask

  task automatic cmp_bit(logic g, logic e);
    samples_checked++;
    if (g !== e) miss(256'(g), 256'(e));
  endtask

  task automatic cmp_vec(logic [216:0] g, logic [216:0] e);
    samples_checked++;
    if (g !== e) miss(256'(g), 256'(e));
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Status lags one cycle; vector checked against outputs
  always @(negedge clock_i)
  begin
    if (st_live)
    begin
      exp_st = st_of(last_st, 1'b0);
      slice  = vec_of(trc_instr_o, exp_st, exp_vld);
      cmp_stat(trc_status_o, exp_st);
      cmp_stat(sm_status, st_of(last_st, 1'b1));
      cmp_bit(trc_valid_instr_o, exp_vld);
      cmp_bit(step_ready_o, occ != 2'h2);
      cmp_vec(trc_cmp_vec_o[3767:3551], slice);
      cmp_bit(trc_cmp_vec_o[itp_pkg::POS_VALID], trc_valid_instr_o);
      cmp_bit(trc_cmp_vec_o[3766], trc_status_o.debug_halted);
      cmp_bit(|trc_cmp_vec_o[4095:3768], 1'b0);
      cmp_bit(|trc_cmp_vec_o[3550:0], 1'b0);
      cmp_bit(sm_instr.jmp_hit | sm_vec[3767], 1'b0);
      cmp_bit(|sm_vec[3765:3764], 1'b0);
      if (trc_valid_instr_o === 1'b1)
        cmp_bit(trc_cmp_vec_o[3677], trc_instr_o.exc_taken);
    end
    st_live  <= (reset_i === 1'b0);
    last_st  = itp_pkg::itp_status_t'(xs(s2));
    status_i <= last_st;
  end

  // Held until taken; a full buffer refuses the step
  task automatic send(itp_pkg::itp_instr_t s, bit gap);
    int n;
    @(negedge clock_i);
    step_valid_i <= 1'b1;
    step_i       <= s;
    n = 0;
    while (step_ready_o !== 1'b1 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
    if (n == 200)
    begin
      miss(256'(n), 256'(0));
      close_out();
    end
    else
    begin
      @(posedge clock_i);
      exp_q.push_back(exp_of(s));
      if (gap)
      begin
        @(negedge clock_i);
        step_valid_i <= 1'b0;
      end
    end
  endtask

  function automatic itp_pkg::itp_instr_t rnd_step();
    logic [223:0] b;
    b = {xs(s1), xs(s1), xs(s1), xs(s1), xs(s1), xs(s1), xs(s1)};
    return b[$bits(itp_pkg::itp_instr_t)-1:0];
  endfunction

  initial
  begin
    itp_pkg::itp_instr_t s;
    logic [4:0] codes[7] = '{5'h01, 5'h05, 5'h0a, 5'h0b, 5'h0c, 5'h08, 5'h1f};
    int n;
    repeat (8) @(negedge clock_i);
    reset_i <= 1'b0;
    foreach (codes[i])
    begin
      s = rnd_step();
      s.exc_taken = 1'b1;
      s.exc_kind  = codes[i];
      send(s, 1'b0);
    end
    s = rnd_step();
    {s.reg_wr, s.d_access, s.d_read, s.d_write} = 4'hf;
    send(s, 1'b0);
    s.reg_wr   = 1'b0;
    s.d_access = 1'b0;
    send(s, 1'b1);
    for (int i = 0; i < 300; i++)
    begin
      slow <= i[6];
      send(rnd_step(), xs(s1) < 32'h2000_0000);
    end
    @(negedge clock_i);
    step_valid_i <= 1'b0;
    n = 0;
    while (u_smp.seen_q.size() < exp_q.size() && n < 3000)
    begin
      @(negedge clock_i);
      n++;
    end
    if (n == 3000)
      miss(256'(n), 256'(0));
    repeat (4) @(negedge clock_i);
    cmp_bit(u_smp.seen_q.size() == exp_q.size(), 1'b1);
    foreach (exp_q[i])
      if (i < u_smp.seen_q.size())
        cmp_instr(u_smp.seen_q[i], exp_q[i]);
    close_out();
  end
endmodule
